// [src/csu_pkg.sv]
// Purpose: Shared constants and types for the clock synthesis unit.
// Assumes: One 125 MHz register clock; reference clocks arrive as levels.
// Notes: All clock outputs are produced as registered levels, never gated.
package csu_pkg;
    // Width of the oscillator trim field.
    localparam int TRIM_W = 10;
    // Position of the trim field in the oscillator control register.
    localparam int TRIM_LSB = 0;
    // Reset value of the trim field until software writes a trim.
    localparam logic [9:0] TRIM_RESET = 10'h200;
    // Width of the postscaler select field.
    localparam int POST_W = 3;
    // Reset value of the postscaler select (divide by one).
    localparam logic [2:0] POST_RESET = 3'h0;
    // Largest legal postscaler code (divide by 32).
    localparam logic [2:0] POST_MAX = 3'h5;
    // Multiplication factor of the synthesis path.
    localparam int MULT = 8;
    // Reset value of the reference select (relaxation oscillator).
    localparam logic SRC_RESET = 1'b0;
    // Time without a rising reference edge after which it counts as lost.
    localparam int LOSS_TIME_NS = 2000;
    localparam int CLK_NS = 8;
    // Longest wait rounds down to whole cycles.
    localparam int LOSS_CYC = LOSS_TIME_NS / CLK_NS;
    localparam int LOSS_W = 8;
    // Cycles of silence on the output while a switch settles.
    localparam logic [3:0] QUIET_CYC = 4'h4;

    // Switch sequencer states.
    typedef enum logic [1:0] {CSU_RUN, CSU_DRAIN, CSU_QUIET} csu_state_t;
endpackage

// [src/csu_sync3.sv]
// Purpose: Three-stage synchroniser for an asynchronous level.
// Assumes: The input may change at any time relative to clk.
// Notes: A change is taken once the second and third stages agree.
module csu_sync3 (
    input wire logic clk,
    input wire logic resetn,
    input wire logic din,
    output logic dout
);
    // Stage one is read only by stage two.
    logic s1_q, s2_q, s3_q;
    // Filtered level, updated only when the last two stages agree.
    logic out_q;

    // Shift chain and agreement filter.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                out_q <= s3_q;
            end
        end
    end

    assign dout = out_q;
endmodule

// [src/csu_top.sv]
// Purpose: Reference select, times-eight multiplier and postscaler.
// Assumes: Reference clocks are far slower than clk and arrive as levels.
// Notes: The multiplier is modelled by measuring the reference period and
// Notes: toggling the output eight times faster; no analog loop here.
module csu_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic relax_clk,
    input wire logic crystal_input_pin,
    input wire logic external_clock_pin,
    input wire logic external_clock_pin_alt,
    input wire logic clock_source_select,
    input wire logic ext_use_crystal,
    input wire logic ext_use_secondary,
    input wire logic synth_bypass,
    input wire logic [csu_pkg::POST_W-1:0] postscaler_sel,
    input wire logic relax_standby,
    input wire logic relax_powerdown,
    input wire logic [csu_pkg::TRIM_W-1:0] trim_wr_data,
    input wire logic trim_wr,
    input wire logic [csu_pkg::TRIM_W-1:0] factory_trim,
    output logic clk2x,
    output logic [csu_pkg::TRIM_W-1:0] oscillator_trim,
    output logic [csu_pkg::TRIM_W-1:0] flash_option_word_one,
    output logic relax_standby_out,
    output logic relax_powerdown_out,
    output logic ref_lost,
    output logic switching
);
    import csu_pkg::*;

    // Whole state of the block in one record.
    typedef struct packed {
        csu_state_t st;
        // Applied configuration, changed only at the drain step.
        logic src;
        logic ext_crystal_output_pin;
        logic ext_sec;
        logic bypass;
        logic [POST_W-1:0] post;
        // Trim and flash option words.
        logic [TRIM_W-1:0] trim;
        logic [TRIM_W-1:0] fopt;
        logic fopt_loaded;
        // Relaxation oscillator power controls.
        logic stby;
        logic pdn;
        // Reference period measurement.
        logic ref_prev;
        logic [LOSS_W-1:0] per_cnt;
        logic [LOSS_W-1:0] period;
        // Set when the next reference edge only restarts the count.
        logic resync;
        // Multiplier and postscaler.
        logic [LOSS_W-1:0] half_cnt;
        logic mult_ph;
        logic [4:0] post_cnt;
        logic synth_clk;
        // Loss flag and output sequencing.
        logic lost;
        logic [3:0] quiet;
        logic out;
    } csu_state_rec_t;

    csu_state_rec_t s_q, s_d;

    // Synchronised reference levels.
    logic relax_s, crystal_output_pin_s, pri_s, sec_s;
    // Currently selected reference level.
    logic ref_s;
    // Requested configuration differs from the applied one.
    logic cfg_change;

    csu_sync3 u_sync_relax (.clk(clk), .resetn(resetn),
        .din(relax_clk), .dout(relax_s));
    csu_sync3 u_sync_crystal_output_pin (.clk(clk), .resetn(resetn),
        .din(crystal_input_pin), .dout(crystal_output_pin_s));
    csu_sync3 u_sync_pri (.clk(clk), .resetn(resetn),
        .din(external_clock_pin), .dout(pri_s));
    csu_sync3 u_sync_sec (.clk(clk), .resetn(resetn),
        .din(external_clock_pin_alt), .dout(sec_s));

    // Postscaler code to the last count of multiplier edges per output
    // half period: a divide by D toggles after D edges, so D minus one.
    function automatic logic [4:0] post_half(input logic [POST_W-1:0] c);
        logic [POST_W-1:0] k;
        k = (c > POST_MAX) ? POST_MAX : c;
        return 5'((6'h01 << k) - 6'h01);
    endfunction

    // Reference mux; a powered down relaxation oscillator gives no edges.
    always_comb begin
        if (s_q.src == SRC_RESET) begin
            ref_s = relax_s & ~s_q.pdn;
        end else if (s_q.ext_crystal_output_pin) begin
            ref_s = crystal_output_pin_s;
        end else begin
            ref_s = s_q.ext_sec ? sec_s : pri_s;
        end
    end

    // A switch is pending when any requested field differs.
    assign cfg_change = (clock_source_select != s_q.src) ||
        (ext_use_crystal != s_q.ext_crystal_output_pin) ||
        (ext_use_secondary != s_q.ext_sec) ||
        (synth_bypass != s_q.bypass) ||
        (postscaler_sel != s_q.post);

    // Next-state logic for every field of the record.
    always_comb begin
        s_d = s_q;
        s_d.ref_prev = ref_s;
        // Factory trim is captured once after reset release.
        if (!s_q.fopt_loaded) begin
            s_d.fopt = factory_trim;
            s_d.fopt_loaded = 1'b1;
        end
        // Software trim write; the value goes straight to the oscillator.
        if (trim_wr) begin
            s_d.trim = trim_wr_data;
        end
        s_d.stby = relax_standby;
        // Power-down is honoured only when the relaxation source is idle.
        s_d.pdn = relax_powerdown && (s_q.src != SRC_RESET);
        // Period measurement of the reference, in clk cycles.
        if (ref_s && !s_q.ref_prev) begin
            s_d.per_cnt = '0;
            s_d.resync = 1'b0;
            // A partial period after a switch would race the multiplier.
            if (!s_q.resync) begin
                s_d.period = s_q.per_cnt;
                s_d.lost = 1'b0;
            end
        end else if (s_q.per_cnt == LOSS_W'(LOSS_CYC)) begin
            s_d.lost = 1'b1;
        end else begin
            s_d.per_cnt = s_q.per_cnt + 1'b1;
        end
        // Toggle sixteen times per reference period (times-eight multiply).
        if (s_q.lost) begin
            s_d.half_cnt = '0;
            s_d.mult_ph = 1'b0;
        end else if (s_q.half_cnt >= (s_q.period >> 4)) begin
            s_d.half_cnt = '0;
            s_d.mult_ph = ~s_q.mult_ph;
        end else begin
            s_d.half_cnt = s_q.half_cnt + 1'b1;
        end
        // Postscaler counts multiplier edges; divide by one passes through.
        if (s_q.post == 3'h0) begin
            s_d.synth_clk = s_d.mult_ph;
        end else if (s_d.mult_ph != s_q.mult_ph) begin
            if (s_q.post_cnt >= post_half(s_q.post)) begin
                s_d.post_cnt = '0;
                s_d.synth_clk = ~s_q.synth_clk;
            end else begin
                s_d.post_cnt = s_q.post_cnt + 5'h01;
            end
        end
        // Output selection and glitch-free switch sequencing.
        unique case (s_q.st)
            CSU_RUN: begin
                // Bypass follows the reference; otherwise the divider.
                if (s_q.bypass) begin
                    s_d.out = ref_s;
                end else begin
                    s_d.out = s_q.synth_clk & ~s_q.lost;
                end
                if (cfg_change) begin
                    s_d.st = CSU_DRAIN;
                end
            end
            CSU_DRAIN: begin
                // Hold high phase until it ends naturally; never cut it.
                if (!s_q.out || (s_q.bypass ? !ref_s : !s_q.synth_clk)) begin
                    s_d.out = 1'b0;
                    s_d.src = clock_source_select;
                    s_d.ext_crystal_output_pin = ext_use_crystal;
                    s_d.ext_sec = ext_use_secondary;
                    s_d.bypass = synth_bypass;
                    s_d.post = postscaler_sel;
                    s_d.post_cnt = '0;
                    s_d.synth_clk = 1'b0;
                    // Restart the period count on the new reference.
                    s_d.per_cnt = '0;
                    s_d.resync = 1'b1;
                    s_d.quiet = QUIET_CYC;
                    s_d.st = CSU_QUIET;
                end
            end
            CSU_QUIET: begin
                // Output low while the new source settles, then resume on
                // a low level so the first high phase is full length.
                s_d.out = 1'b0;
                if (s_q.quiet != 4'h0) begin
                    s_d.quiet = s_q.quiet - 4'h1;
                end else if (s_q.bypass ? !ref_s : !s_q.synth_clk) begin
                    s_d.st = CSU_RUN;
                end
            end
        endcase
    end

    // Single state register; reset picks the relaxation oscillator.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.st <= CSU_RUN;
            s_q.src <= SRC_RESET;
            s_q.post <= POST_RESET;
            s_q.trim <= TRIM_RESET;
            s_q.fopt <= TRIM_RESET;
            s_q.lost <= 1'b1;
            s_q.resync <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign clk2x = s_q.out;
    assign oscillator_trim = s_q.trim;
    assign flash_option_word_one = s_q.fopt;
    assign relax_standby_out = s_q.stby;
    assign relax_powerdown_out = s_q.pdn;
    assign ref_lost = s_q.lost;
    assign switching = (s_q.st != CSU_RUN);
endmodule

// [sim/csu_sys_model.sv]
// Purpose: System side model that halves the 2X clock.
// Assumes: clk2x is a registered level in the clk domain.
// Notes: Sampling on clk keeps the model in one clock domain.
module csu_sys_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk2x,
    output logic sys_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q;
    // Every rising edge of the 2X clock flips the system clock.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_q <= 1'b0;
            sys_clk <= 1'b0;
        end else begin
            last_q <= clk2x;
            if (clk2x && !last_q) sys_clk <= !sys_clk;
        end
    end
endmodule

// [sim/csu_top_monitor.sv]
// Purpose: Port assertions for the clock synthesis unit.
// Assumes: Inputs stay still while switching is high.
// Notes: References are slower than 32 clk cycles a period.
module csu_top_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [csu_pkg::POST_W-1:0] postscaler_sel,
    input wire logic clock_source_select,
    input wire logic relax_standby,
    input wire logic trim_wr,
    input wire logic [csu_pkg::TRIM_W-1:0] trim_wr_data,
    input wire logic [csu_pkg::TRIM_W-1:0] factory_trim,
    input wire logic clk2x,
    input wire logic [csu_pkg::TRIM_W-1:0] oscillator_trim,
    input wire logic [csu_pkg::TRIM_W-1:0] flash_option_word_one,
    input wire logic relax_standby_out,
    input wire logic relax_powerdown_out,
    input wire logic ref_lost,
    input wire logic switching
);
    timeunit 1ns;
    timeprecision 1ps;
    import csu_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_trim_wr;
        trim_wr |=> oscillator_trim == $past(trim_wr_data);
    endproperty
    a_trim_wr: assert property (p_trim_wr)
        else $error("trim not written");
    property p_trim_hold;
        !trim_wr |=> $stable(oscillator_trim);
    endproperty
    a_trim_hold: assert property (p_trim_hold)
        else $error("trim changed without write");
    property p_flash;
        !$past(resetn) |=> flash_option_word_one == $past(factory_trim);
    endproperty
    a_flash: assert property (p_flash)
        else $error("factory trim not loaded");
    property p_switch;
        $changed(postscaler_sel) && !switching |-> ##[1:2] switching;
    endproperty
    a_switch: assert property (p_switch)
        else $error("postscaler change not taken");
    // The output must rest low before a new setting runs.
    property p_quiet;
        $fell(switching) |-> !$past(clk2x, 1) && !$past(clk2x, 2)
            && !$past(clk2x, 3);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("clk2x not quiet at switch end");
    property p_runt;
        !$stable(clk2x) |=> $stable(clk2x);
    endproperty
    a_runt: assert property (p_runt)
        else $error("runt pulse on clk2x");
    property p_stby;
        1'b1 |=> relax_standby_out == $past(relax_standby);
    endproperty
    a_stby: assert property (p_stby)
        else $error("standby not passed on");
    property p_pd;
        !switching && !clock_source_select && $stable(clock_source_select)
            |=> !relax_powerdown_out;
    endproperty
    a_pd: assert property (p_pd)
        else $error("relaxation powered down while in use");
    c_switch: cover property ($rose(switching));
    c_lost: cover property ($rose(ref_lost));
    c_trim: cover property (trim_wr ##1 trim_wr);
endmodule
bind csu_top csu_top_monitor u_mon (.*);

// [sim/csu_top_tb.sv]
// Purpose: Self-checking bench for the clock synthesis unit.
// Assumes: Reference periods of 128 to 224 clk cycles.
// Notes: Periods are measured rise to rise with one cycle slack.
module csu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import csu_pkg::*;
    localparam logic [9:0] FACTORY = 10'h1a5;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] refs = 4'h0;
    logic [3:0] ref_on = 4'hf;
    logic src = 1'b0, crystal_output_pin = 1'b0, sec = 1'b0, byp = 1'b1;
    logic [2:0] post = 3'h0;
    logic stby = 1'b0, pdown = 1'b0, twr = 1'b0;
    logic [9:0] td = 10'h000;
    logic [9:0] trim_o, flash_o;
    logic clk2x, stby_o, pdown_o, lost, busy, sys_clk;
    logic [7:0] lfsr = 8'h23;
    int half[4] = '{64, 80, 96, 112};
    int cnt[4] = '{0, 0, 0, 0};
    int codes[$] = '{0, 1, 2, 3, 4, 5};
    int n_errors = 0, check_count = 0, cyc = 0, p, e;
    csu_top DUT (.clk(clk), .resetn(resetn), .relax_clk(refs[0]),
        .crystal_input_pin(refs[1]), .external_clock_pin(refs[2]),
        .external_clock_pin_alt(refs[3]), .clock_source_select(src),
        .ext_use_crystal(crystal_output_pin), .ext_use_secondary(sec),
        .synth_bypass(byp), .postscaler_sel(post), .relax_standby(stby),
        .relax_powerdown(pdown), .trim_wr_data(td), .trim_wr(twr),
        .factory_trim(FACTORY), .clk2x(clk2x), .oscillator_trim(trim_o),
        .flash_option_word_one(flash_o), .relax_standby_out(stby_o),
        .relax_powerdown_out(pdown_o), .ref_lost(lost), .switching(busy));
    csu_sys_model SYS (.clk(clk), .resetn(resetn), .clk2x(clk2x),
        .sys_clk(sys_clk));
    always #4 clk = ~clk;
    // Each reference flips after its half period while it runs.
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= (cnt[i] == half[i] - 1) ? 0 : cnt[i] + 1;
            if (ref_on[i] && cnt[i] == half[i] - 1) refs[i] <= !refs[i];
        end
    end
    // A hang counts as a mismatch.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            wrap_up();
        end
    end
    function automatic logic [7:0] nxt(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(string nm, logic [9:0] x, logic [9:0] s);
        check_count++;
        if (s !== x) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic chk_p(string nm, int x, int s);
        check_count++;
        if (s < x - 1 || s > x + 1) begin
            n_errors++;
            $display("Error %s expected %0d seen %0d", nm, x, s);
        end
    endtask
    // Cycles between two rising edges, capped so a dead clock ends.
    task automatic measure(bit sy, output int n);
        logic pv, cu;
        int r;
        int w;
        r = 0;
        w = 0;
        n = 0;
        pv = sy ? sys_clk : clk2x;
        while (r < 2 && w < 4000 && cyc < 79000) begin
            @(posedge clk);
            #1;
            w++;
            cu = sy ? sys_clk : clk2x;
            if (cu === 1'b1 && pv === 1'b0) r++;
            if (r == 1) n++;
            pv = cu;
        end
    endtask
    // The new reference runs three steady periods after any setting change.
    task automatic apply(int s, logic b, logic [2:0] ps);
        int k;
        @(posedge clk);
        src <= (s != 0);
        crystal_output_pin <= (s == 1);
        sec <= (s == 3);
        byp <= b;
        post <= ps;
        k = 0;
        repeat (3) @(posedge clk);
        #1;
        while (busy !== 1'b0 && k < 2000) begin
            @(posedge clk);
            #1;
            k++;
        end
        // A switch that never ends counts as a mismatch.
        if (k >= 2000) n_errors++;
        repeat (6 * half[s]) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1;
        chk("clk2x", 1'b0, clk2x);
        chk("trim", TRIM_RESET, trim_o);
        chk("lost", 1'b1, lost);
        @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("flash", FACTORY, flash_o);
        // Boot code copies the factory word, then random trims follow.
        @(posedge clk);
        td <= flash_o;
        twr <= 1'b1;
        @(posedge clk);
        #1;
        chk("trim", FACTORY, trim_o);
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            @(posedge clk);
            td <= {lfsr[1:0], lfsr};
            @(posedge clk);
            #1;
            chk("trim", {lfsr[1:0], lfsr}, trim_o);
        end
        @(posedge clk);
        twr <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            apply(s, 1'b1, 3'h0);
            measure(1'b0, p);
            chk_p("bypass", 2 * half[s], p);
        end
        codes.push_back(6 + lfsr[0]);
        foreach (codes[i]) begin
            apply(3, 1'b0, codes[i][2:0]);
            measure(1'b0, p);
            e = 2 * half[3] * (1 << (codes[i] > 5 ? 5 : codes[i])) / MULT;
            chk_p("synth", e, p);
        end
        measure(1'b1, p);
        chk_p("sysclk", 2 * e, p);
        @(posedge clk);
        pdown <= 1'b1;
        stby <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("pdown", 1'b1, pdown_o);
        chk("stby", 1'b1, stby_o);
        apply(0, 1'b0, 3'h0);
        chk("pdown", 1'b0, pdown_o);
        @(posedge clk);
        ref_on[0] <= 1'b0;
        p = 0;
        while (lost !== 1'b1 && p < 600) begin
            @(posedge clk);
            p++;
        end
        chk("lost", 1'b1, p <= LOSS_CYC + 2 * half[0] + 8);
        measure(1'b0, p);
        chk_p("dead", 0, p);
        wrap_up();
    end
endmodule
